/* shared/eta_pkg.sv */
/*
 * shared constants and types of the encoder and trigger acquisition
 * block: timing, reset values, modes, configuration carriers, state.
 * assumes a single 200 MHz system clock.
 */
package eta_pkg;

    // ------
    // timing
    // ------
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned RATE_MIN_HZ  = 100;
    localparam int unsigned RATE_MAX_S   = 8_000;
    localparam int unsigned RATE_MAX_L   = 25_000;
    localparam int          RATE_W       = 15;
    localparam int          ACC_W        = 28;
    localparam int unsigned EXPO_MAX_US  = 10_000;
    localparam int unsigned EXPO_MAX_CYC =
        EXPO_MAX_US * (CLK_HZ / 1_000_000);
    localparam int          EXPO_W       = $clog2(EXPO_MAX_CYC + 1);
    localparam int          BURST_W      = 16;
    localparam int          PEAK_W       = 12;
    localparam int          N_ENC        = 3;

    // ------
    // modes
    // ------
    typedef enum logic [1:0] {INTP_X1, INTP_X2, INTP_X4} eta_intp_t;
    typedef enum logic [1:0] {REF_NONE, REF_ONCE, REF_ALL} eta_ref_t;
    typedef enum logic [1:0] {
        SYNC_OFF, SYNC_MASTER, SYNC_SLAVE, SYNC_MFI
    } eta_sync_t;
    typedef enum logic [2:0] {
        TRG_OFF, TRG_LEVEL, TRG_EDGE, TRG_SOFT, TRG_ENC
    } eta_trg_t;
    typedef enum logic [1:0] {LVL_GREEN, LVL_YELLOW, LVL_RED} eta_lvl_t;

    // ------
    // configuration carriers
    // ------
    typedef struct packed {
        eta_intp_t   intp;
        eta_ref_t    ref_mode;
        logic [31:0] max_val;
        logic [31:0] preset;
    } eta_enc_cfg_t;

    typedef struct packed {
        eta_trg_t           mode;
        logic               pol_high;
        logic               burst_inf;
        logic [BURST_W-1:0] burst_n;
        logic               enc_sel;
        logic [31:0]        lo;
        logic [31:0]        hi;
        logic [31:0]        inc;
    } eta_trg_cfg_t;

    // ------
    // state and reset values
    // ------
    typedef struct packed {
        logic [2:0]  a;
        logic [2:0]  b;
        logic [2:0]  z;
        logic        armed;
        logic        init;
        logic [31:0] cnt;
    } eta_enc_st_t;

    localparam eta_enc_st_t ENC_ST_RST = '{
        a: 3'h0, b: 3'h0, z: 3'h0, armed: 1'b1, init: 1'b1,
        cnt: 32'h0};

    typedef struct packed {
        logic [2:0]            sy;
        logic [ACC_W-1:0]      acc;
        logic                  tick;
        logic                  sync_out;
        logic                  rs_en;
        logic [EXPO_W-1:0]     half;
        logic                  busy;
        logic [N_ENC-1:0][31:0] lat;
        logic [N_ENC-1:0][31:0] val;
        logic                  val_vld;
        logic                  rec_frame;
        logic                  burst_on;
        logic [BURST_W-1:0]    left;
        logic                  enc_pend;
        logic [31:0]           tgt;
        eta_lvl_t              lvl;
    } eta_top_st_t;

    localparam eta_top_st_t TOP_ST_RST = '{
        lvl: LVL_GREEN, rs_en: 1'b1, default: '0};

endpackage

/* src/eta_enc_counter.sv */
/*
 * one quadrature encoder counter: synchronises the three tracks,
 * decodes direction, counts interpolated edges, wraps at a maximum
 * and loads a preset at start-up, on command or on reference marks.
 * assumes track inputs that change far slower than the clock.
 */
`timescale 1ns/1ps

module eta_enc_counter
    import eta_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         trk_a_i,
    input  wire logic         trk_b_i,
    input  wire logic         trk_ref_i,
    input  wire logic         ref_use_i,
    input  wire eta_enc_cfg_t cfg_i,
    input  wire logic         set_i,
    input  wire logic         rearm_i,
    output logic [31:0]       pos_o
);

    eta_enc_st_t q;
    eta_enc_st_t d;
    logic        a_ed;
    logic        b_ed;
    logic        step;
    logic        up;
    logic        mark;

    // ------
    // decode and count
    // ------
    // bit 0 is the first synchroniser stage, bit 2 the previous value
    always_comb begin
        d      = q;
        d.a    = {q.a[1:0], trk_a_i};
        d.b    = {q.b[1:0], trk_b_i};
        d.z    = {q.z[1:0], trk_ref_i};
        a_ed   = q.a[1] ^ q.a[2];
        b_ed   = q.b[1] ^ q.b[2];
        step   = 1'b0;
        up     = 1'b0;
        // a leads b when moving up; the level pair gives direction
        unique case (cfg_i.intp)
            INTP_X1: begin
                step = a_ed & q.a[1];
                up   = ~q.b[1];
            end
            INTP_X2: begin
                step = a_ed;
                up   = q.a[1] ^ q.b[1];
            end
            INTP_X4: begin
                step = a_ed | b_ed;
                up   = a_ed ? (q.a[1] ^ q.b[1]) : ~(q.a[1] ^ q.b[1]);
            end
            default: begin
                step = 1'b0;
                up   = 1'b0;
            end
        endcase
        mark = ref_use_i & q.z[1] & ~q.z[2];
        // start-up load and command load beat marks and counting
        if (q.init || set_i) begin
            d.cnt  = cfg_i.preset;
            d.init = 1'b0;
        end else if (mark && cfg_i.ref_mode == REF_ALL) begin
            d.cnt = cfg_i.preset;
        end else if (mark && cfg_i.ref_mode == REF_ONCE && q.armed) begin
            d.cnt   = cfg_i.preset;
            d.armed = 1'b0;
        end else if (step && up) begin
            d.cnt = (q.cnt >= cfg_i.max_val) ? 32'h0 : q.cnt + 32'h1;
        end else if (step) begin
            d.cnt = (q.cnt == 32'h0) ? cfg_i.max_val : q.cnt - 32'h1;
        end
        // in no-effect mode marks fall through unused
        if (rearm_i) begin
            d.armed = 1'b1;
        end
    end

    // wrap in both directions keeps the count inside 0..max
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q <= ENC_ST_RST;
        end else begin
            q <= d;
        end
    end

    assign pos_o = q.cnt;

endmodule

/* src/eta_acq_top.sv */
/*
 * encoder and trigger acquisition control: measurement cycle timing,
 * multi-controller sync, three encoder counters, mid-exposure
 * latching of encoder values, trigger gating and intensity status.
 * assumes an exposure engine that reports the start, length and end
 * of each exposure, and configuration held steady by its owner.
 */
// Operation
// - report encoder counts latched at the middle of each exposure
// - quadrature tracks decide direction: up one way, down other
// - x1, x2 or x4 interpolation picks counted edges, one step each
// - 32-bit counters wrap to zero past the configured maximum
// - no-effect mode ignores marks; preset loads at start or command
// - one-time mode loads preset at first mark, until re-armed
// - every-mark mode loads preset on each reference mark
// - preset loads at start and on command; kept below maximum
// - reset-reference command re-arms first-mark detection
// - two encoders turn off RS422 output and synchronization
// - three encoders mask reference tracks of encoders one and two
// - sync role master, slave, multifunction or inactive
// - cycle rate 0.1 kHz to 8 or 25 kHz in 1 Hz steps
// - intensity red saturated, yellow weak, green good; never stops
// - triggers gate recorded cycles, never the measuring rate
// - trigger inactive records continuously from power-on
// - level trigger records while the chosen level is present
// - edge trigger starts on chosen edge; pulses 5 us or more
// - edge and software triggers release a count or endless run
// - software trigger starts by command; trigger pin ignored
// - encoder trigger uses encoder one or two with limits
`timescale 1ns/1ps

module eta_acq_top
    import eta_pkg::*;
#(
    parameter bit                LARGE_VARIANT = 1'b1,
    parameter logic [PEAK_W-1:0] LVL_SAT       = 12'hf00,
    parameter logic [PEAK_W-1:0] LVL_WEAK      = 12'h100
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic [N_ENC-1:0]       enc_a_i,
    input  wire logic [N_ENC-1:0]       enc_b_i,
    input  wire logic [N_ENC-1:0]       enc_ref_i,
    input  wire eta_enc_cfg_t [N_ENC-1:0] enc_cfg_i,
    input  wire logic [1:0]             enc_num_i,
    input  wire logic [N_ENC-1:0]       enc_set_i,
    input  wire logic [N_ENC-1:0]       enc_next_i,
    input  wire logic [N_ENC-1:0]       enc_rref_i,
    input  wire logic [RATE_W-1:0]      rate_hz_i,
    input  wire eta_sync_t              sync_role_i,
    input  wire logic                   sync_i,
    input  wire eta_trg_cfg_t           trg_cfg_i,
    input  wire logic                   soft_trig_i,
    input  wire logic                   expo_start_i,
    input  wire logic [EXPO_W-1:0]      expo_len_i,
    input  wire logic                   expo_done_i,
    input  wire logic [PEAK_W-1:0]      peak_i,
    output logic                        cycle_o,
    output logic                        sync_o,
    output logic                        rs422_en_o,
    output logic                        val_valid_o,
    output logic [N_ENC-1:0][31:0]      val_enc_o,
    output eta_lvl_t                    intensity_o
);

    // ------
    // elaboration checks
    // ------
    localparam int unsigned RATE_MAX =
        LARGE_VARIANT ? RATE_MAX_L : RATE_MAX_S;

    if (LVL_WEAK >= LVL_SAT) begin : g_bad_lvl
        $error("weak level must lie below saturation level");
    end
    if (RATE_MAX >= (1 << RATE_W)) begin : g_bad_rate
        $error("rate width too narrow for the maximum rate");
    end

    // ------
    // encoder counters
    // ------
    logic [N_ENC-1:0][31:0] pos;
    logic [N_ENC-1:0]       ref_use;

    for (genvar i = 0; i < N_ENC; i++) begin : g_enc
        // with three encoders the first two reference pins carry other
        // tracks, so their marks must never reach the counters
        assign ref_use[i] = !(enc_num_i == 2'd3 && i < 2);

        eta_enc_counter u_cnt (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .trk_a_i   (enc_a_i[i]),
            .trk_b_i   (enc_b_i[i]),
            .trk_ref_i (enc_ref_i[i]),
            .ref_use_i (ref_use[i]),
            .cfg_i     (enc_cfg_i[i]),
            .set_i     (enc_set_i[i]),
            .rearm_i   (enc_next_i[i] | enc_rref_i[i]),
            .pos_o     (pos[i])
        );
    end

    // ------
    // combinational helpers
    // ------
    eta_top_st_t       q;
    eta_top_st_t       d;
    logic              pin_free;
    logic              mfi;
    logic              pin_lvl;
    logic              pin_edge;
    logic [RATE_W-1:0] rate;
    logic [ACC_W:0]    acc_sum;
    logic              int_tick;
    logic              tick;
    logic              start_burst;
    logic [31:0]       epos;
    logic [32:0]       nxt;
    logic              hit;

    // ------
    // next state
    // ------
    always_comb begin
        d = q;

        // the shared pins are taken by the second encoder
        pin_free = (enc_num_i != 2'd2);
        mfi      = pin_free && sync_role_i == SYNC_MFI;
        d.rs_en  = pin_free;

        // sync pin: two stages, then a copy for edge detection
        d.sy     = {q.sy[1:0], sync_i};
        pin_lvl  = mfi && (q.sy[1] == trg_cfg_i.pol_high);
        pin_edge = mfi && (q.sy[1] != q.sy[2])
                   && (q.sy[1] == trg_cfg_i.pol_high);

        // rate clamp; a phase accumulator hits every 1 Hz step exactly
        // where a divider would only reach integer periods
        if (rate_hz_i < RATE_W'(RATE_MIN_HZ)) begin
            rate = RATE_W'(RATE_MIN_HZ);
        end else if (rate_hz_i > RATE_W'(RATE_MAX)) begin
            rate = RATE_W'(RATE_MAX);
        end else begin
            rate = rate_hz_i;
        end
        acc_sum  = {1'b0, q.acc} + {{(ACC_W + 1 - RATE_W){1'b0}}, rate};
        int_tick = acc_sum >= (ACC_W + 1)'(CLK_HZ);
        d.acc    = int_tick ? ACC_W'(acc_sum - (ACC_W + 1)'(CLK_HZ))
                            : acc_sum[ACC_W-1:0];

        // a slave takes its cycle from the master's pulse on the pin
        if (pin_free && sync_role_i == SYNC_SLAVE) begin
            tick = q.sy[1] & ~q.sy[2];
        end else begin
            tick = int_tick;
        end
        d.tick     = tick;
        d.sync_out = pin_free && sync_role_i == SYNC_MASTER
                     && int_tick;

        // midpoint latch: the exposure length may change each cycle,
        // so the half count is taken fresh at every exposure start
        if (expo_start_i) begin
            d.half = expo_len_i >> 1;
            d.busy = 1'b1;
        end else if (q.busy && q.half == '0) begin
            d.lat  = pos;
            d.busy = 1'b0;
        end else if (q.busy) begin
            d.half = q.half - EXPO_W'(1);
        end

        // a finished exposure is reported only if its cycle was gated in
        d.val_vld = expo_done_i && q.rec_frame;
        if (expo_done_i && q.rec_frame) begin
            d.val = q.lat;
        end

        // encoder window: the target walks lo, lo+inc, ... up to hi
        epos = trg_cfg_i.enc_sel ? pos[1] : pos[0];
        nxt  = {1'b0, q.tgt} + {1'b0, trg_cfg_i.inc};
        hit  = trg_cfg_i.mode == TRG_ENC && epos == q.tgt
               && epos >= trg_cfg_i.lo && epos <= trg_cfg_i.hi;
        // new limits leave a stale target; restart the walk at lo
        if (trg_cfg_i.mode != TRG_ENC || q.tgt < trg_cfg_i.lo
            || q.tgt > trg_cfg_i.hi) begin
            d.tgt = trg_cfg_i.lo;
        end else if (hit) begin
            d.tgt = (nxt > {1'b0, trg_cfg_i.hi} || trg_cfg_i.inc == 0)
                    ? trg_cfg_i.lo : nxt[31:0];
        end

        // per-cycle gate, decided at the cycle start only; the rate
        // path above never looks at any trigger state
        if (tick) begin
            unique case (trg_cfg_i.mode)
                TRG_OFF: begin
                    d.rec_frame = 1'b1;
                end
                TRG_LEVEL: begin
                    // a level shorter than a cycle may be missed
                    d.rec_frame = pin_lvl;
                end
                TRG_EDGE, TRG_SOFT: begin
                    d.rec_frame = q.burst_on;
                    if (q.burst_on && !trg_cfg_i.burst_inf) begin
                        d.left     = q.left - BURST_W'(1);
                        d.burst_on = (q.left > BURST_W'(1));
                    end
                end
                TRG_ENC: begin
                    d.rec_frame = q.enc_pend;
                    d.enc_pend  = 1'b0;
                end
                default: begin
                    d.rec_frame = 1'b0;
                end
            endcase
        end

        // new trigger events win over the same-cycle consumption
        unique case (trg_cfg_i.mode)
            TRG_EDGE: start_burst = pin_edge;
            TRG_SOFT: start_burst = soft_trig_i;
            default:  start_burst = 1'b0;
        endcase
        if (start_burst) begin
            d.left     = trg_cfg_i.burst_n;
            d.burst_on = trg_cfg_i.burst_inf || trg_cfg_i.burst_n != 0;
        end
        if (trg_cfg_i.mode != TRG_EDGE && trg_cfg_i.mode != TRG_SOFT) begin
            d.burst_on = 1'b0;
        end
        if (hit) begin
            d.enc_pend = 1'b1;
        end else if (trg_cfg_i.mode != TRG_ENC) begin
            d.enc_pend = 1'b0;
        end

        // status only: acquisition carries on whatever the colour
        if (peak_i >= LVL_SAT) begin
            d.lvl = LVL_RED;
        end else if (peak_i < LVL_WEAK) begin
            d.lvl = LVL_YELLOW;
        end else begin
            d.lvl = LVL_GREEN;
        end
    end

    // ------
    // state register
    // ------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q <= TOP_ST_RST;
        end else begin
            q <= d;
        end
    end

    // ------
    // outputs, all straight from the state register
    // ------
    assign cycle_o     = q.tick;
    assign sync_o      = q.sync_out;
    assign rs422_en_o  = q.rs_en;
    assign val_valid_o = q.val_vld;
    assign val_enc_o   = q.val;
    assign intensity_o = q.lvl;

endmodule

/* testbench/eta_acq_top_chk.sv */
/* checker on the ports of eta_acq_top: pacing, sync, values, colour.
   assumes a 25 kHz rate whenever the role is not slave. */
`timescale 1ns/1ps
module eta_acq_chk
    import eta_pkg::*;
#(
    parameter logic [PEAK_W-1:0] LVL_SAT  = 12'hf00,
    parameter logic [PEAK_W-1:0] LVL_WEAK = 12'h100
) (
    input wire logic                   clk_sys_i,
    input wire logic                   rst_i,
    input wire logic [1:0]             enc_num_i,
    input wire eta_sync_t              sync_role_i,
    input wire logic                   expo_done_i,
    input wire logic [PEAK_W-1:0]      peak_i,
    input wire logic                   cycle_o,
    input wire logic                   sync_o,
    input wire logic                   rs422_en_o,
    input wire logic                   val_valid_o,
    input wire logic [N_ENC-1:0][31:0] val_enc_o,
    input wire eta_lvl_t               intensity_o
);
    localparam int GAP = CLK_HZ / RATE_MAX_L - 1; // idle clocks at 25 kHz
    logic [15:0] gap_q;
    logic        seen_q;

    // ------
    // cycle spacing watch
    // ------
    // slave role is externally paced, so it restarts the watch
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q  <= 16'h0;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= cycle_o ? 16'h0 : gap_q + 16'h1;
            seen_q <= (sync_role_i != SYNC_SLAVE) && (seen_q || cycle_o);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    rate_gap_a:
        assert property (cycle_o && seen_q && sync_role_i != SYNC_SLAVE
            |-> gap_q == GAP) else $error("cycle spacing off");
    rate_late_a:
        assert property (seen_q && sync_role_i != SYNC_SLAVE
            |-> gap_q <= GAP) else $error("cycle tick missing");
    cycle_pulse_a:
        assert property (cycle_o |=> !cycle_o [*8])
            else $error("cycle pulse too long");
    rs422_follow_a:
        assert property (1'b1 |=> rs422_en_o == ($past(enc_num_i) != 2'h2))
            else $error("rs422 enable wrong");
    master_sync_a:
        assert property (cycle_o && sync_role_i == SYNC_MASTER
            && enc_num_i != 2'h2 |-> sync_o) else $error("sync out missing");
    sync_only_a:
        assert property (sync_o |-> cycle_o && sync_role_i == SYNC_MASTER
            && enc_num_i != 2'h2) else $error("stray sync out");
    val_cause_a:
        assert property (val_valid_o |-> $past(expo_done_i))
            else $error("value without finished exposure");
    val_hold_a:
        assert property (!val_valid_o |-> $stable(val_enc_o))
            else $error("encoder values moved between records");
    sat_red_a:
        assert property (peak_i >= LVL_SAT |=> intensity_o == LVL_RED)
            else $error("saturation not red");
    weak_yel_a:
        assert property (peak_i < LVL_WEAK |=> intensity_o == LVL_YELLOW)
            else $error("weak signal not yellow");

    cover property (cycle_o && sync_role_i == SYNC_SLAVE);
    cover property (val_valid_o && sync_role_i == SYNC_MFI);
    cover property (sync_o);
endmodule

bind eta_acq_top eta_acq_chk #(.LVL_SAT(LVL_SAT), .LVL_WEAK(LVL_WEAK))
    u_chk (.clk_sys_i, .rst_i, .enc_num_i, .sync_role_i, .expo_done_i,
           .peak_i, .cycle_o, .sync_o, .rs422_en_o, .val_valid_o,
           .val_enc_o, .intensity_o);

/* testbench/eta_far_model.sv */
/* far side: three encoders moving together, a trigger source
   and a master peer on the sync pin.
   assumes one caller of the tasks at a time. */
`timescale 1ns/1ps
module eta_far_model (
    input  wire logic  clk_sys_i,
    output logic [2:0] enc_a_o,
    output logic [2:0] enc_b_o,
    output logic [2:0] enc_ref_o,
    output logic       sync_o
);
    logic [1:0] ph      = 2'h0;
    logic [2:0] ref_q   = 3'h0;
    logic       trg_q   = 1'b0;
    logic       peer_on = 1'b0;
    int         tck     = 0;

    // phase to tracks: 00, 10, 11, 01 going up
    assign enc_a_o   = {3{ph[0] ^ ph[1]}};
    assign enc_b_o   = {3{ph[1]}};
    assign enc_ref_o = ref_q;
    assign sync_o    = trg_q;

    // peer master: 10-clock pulse every 400 clocks while enabled
    always @(negedge clk_sys_i) begin
        if (peer_on) begin
            tck <= (tck == 399) ? 0 : tck + 1;
            if (tck == 0) trg_q <= 1'b1;
            if (tck == 10) trg_q <= 1'b0;
        end
    end

    // one gray step per call edge; slow enough for the input synchroniser
    task automatic quad(input logic up, input int n);
        repeat (n) begin
            @(negedge clk_sys_i);
            ph = up ? ph + 2'h1 : ph - 2'h1;
            repeat (8) @(negedge clk_sys_i);
        end
    endtask

    task automatic mark();
        @(negedge clk_sys_i);
        ref_q = 3'h7;
        repeat (4) @(negedge clk_sys_i);
        ref_q = 3'h0;
        repeat (8) @(negedge clk_sys_i);
    endtask

    // levels are held across whole cycles, far wider than 5 us
    task automatic pin(input logic v);
        @(negedge clk_sys_i);
        trg_q = v;
    endtask
endmodule

/* testbench/tb_eta_acq_top.sv */
/* bench for eta_acq_top: exposure-cycle tasks and call sequences.
   assumes the far-side model and the bound checker. */
`timescale 1ns/1ps
module tb_eta_acq_top
    import eta_pkg::*;
;
    logic                     clk_sys_i = 1'b0;
    logic                     rst_i, soft_trig_i, expo_start_i, expo_done_i;
    logic                     sync_i, cycle_o, sync_o, rs422_en_o;
    logic                     val_valid_o;
    logic [N_ENC-1:0]         enc_a_i, enc_b_i, enc_ref_i;
    logic [N_ENC-1:0]         enc_set_i, enc_next_i, enc_rref_i;
    logic [1:0]               enc_num_i;
    logic [RATE_W-1:0]        rate_hz_i;
    logic [EXPO_W-1:0]        expo_len_i;
    logic [PEAK_W-1:0]        peak_i;
    logic [N_ENC-1:0][31:0]   val_enc_o;
    eta_enc_cfg_t [N_ENC-1:0] enc_cfg_i;
    eta_sync_t                sync_role_i;
    eta_trg_cfg_t             trg_cfg_i;
    eta_lvl_t                 intensity_o;
    int                       bad_count = 0;
    int                       n_compared = 0;
    int                       got;

    always #2.5 clk_sys_i = ~clk_sys_i;

    eta_far_model far_u (.clk_sys_i, .enc_a_o(enc_a_i), .enc_b_o(enc_b_i),
        .enc_ref_o(enc_ref_i), .sync_o(sync_i));
    eta_acq_top dut_u (.clk_sys_i, .rst_i, .enc_a_i, .enc_b_i, .enc_ref_i,
        .enc_cfg_i, .enc_num_i, .enc_set_i, .enc_next_i, .enc_rref_i,
        .rate_hz_i, .sync_role_i, .sync_i, .trg_cfg_i, .soft_trig_i,
        .expo_start_i, .expo_len_i, .expo_done_i, .peak_i, .cycle_o,
        .sync_o, .rs422_en_o, .val_valid_o, .val_enc_o, .intensity_o);

    // ------
    // tasks
    // ------
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic nx(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // bounded wait for the next cycle pulse
    task automatic wcyc();
        int w;
        w = 0;
        while (cycle_o !== 1'b1) begin
            nx(1);
            w++;
            if (w > 20000) begin
                bad_count++;
                print_verdict();
            end
        end
    endtask

    // one exposure in the next cycle; v counts records seen after it
    task automatic meas(input logic [EXPO_W-1:0] len, output int v);
        v = 0;
        wcyc();
        expo_len_i = len;
        expo_start_i = 1'b1;
        nx(1);
        expo_start_i = 1'b0;
        nx(len);
        expo_done_i = 1'b1;
        nx(1);
        expo_done_i = 1'b0;
        repeat (3) begin
            v += (val_valid_o === 1'b1);
            nx(1);
        end
    endtask

    task automatic rd(input logic [95:0] exp);
        meas(21'h10, got);
        chk(got, 1, "value missing");
        chk(val_enc_o, exp, "encoder counts");
    endtask

    task automatic run(input int n, input int exp);
        int s, v;
        s = 0;
        repeat (n) begin
            meas(21'h10, v);
            s += v;
        end
        chk(s, exp, "record count");
    endtask

    // ------
    // sequence
    // ------
    initial begin
        logic [11:0] pk [3];
        eta_lvl_t    lv [3];
        pk = '{12'hf00, 12'h0ff, 12'h500};
        lv = '{LVL_RED, LVL_YELLOW, LVL_GREEN};
        rst_i = 1'b1;
        {soft_trig_i, expo_start_i, expo_done_i} = 3'h0;
        {enc_set_i, enc_next_i, enc_rref_i} = 9'h000;
        enc_num_i = 2'h1;
        rate_hz_i = 15'h61a8;
        sync_role_i = SYNC_MASTER;
        trg_cfg_i = '0;
        expo_len_i = 21'h0;
        peak_i = 12'h500;
        // presets kept below their maxima
        enc_cfg_i[0] = '{INTP_X1, REF_NONE, 32'hffff_ff00, 32'ha};
        enc_cfg_i[1] = '{INTP_X2, REF_NONE, 32'hffff_ff00, 32'h14};
        enc_cfg_i[2] = '{INTP_X4, REF_NONE, 32'h5, 32'h3};
        nx(10);
        rst_i = 1'b0;
        nx(2);
        meas(21'h10, got);
        enc_num_i = 2'h2;
        rd({32'h3, 32'h14, 32'ha});
        chk(rs422_en_o, 0, "rs422 with two encoders");
        enc_num_i = 2'h1;
        for (int i = 0; i < 3; i++) begin
            peak_i = pk[i];
            nx(3);
            chk(intensity_o, lv[i], "intensity colour");
        end
        chk(rs422_en_o, 1, "rs422 with one encoder");
        $display("done: reset values");
        sync_role_i = SYNC_SLAVE;
        far_u.peer_on = 1'b1;
        far_u.quad(1, 4);
        rd({32'h1, 32'h16, 32'hb});
        // down moves before the midpoint count, up moves after do not
        fork
            meas(21'hc8, got);
            begin
                @(posedge expo_start_i);
                nx(10);
                far_u.quad(0, 4);
                nx(100);
                far_u.quad(1, 4);
            end
        join
        chk(got, 1, "midpoint value");
        chk(val_enc_o, {32'h3, 32'h14, 32'ha}, "midpoint counts");
        $display("done: counting");
        enc_cfg_i[0].ref_mode = REF_ONCE;
        enc_cfg_i[1].ref_mode = REF_ALL;
        far_u.mark();
        far_u.quad(1, 4);
        far_u.mark();
        rd({32'h5, 32'h14, 32'hb});
        enc_next_i = 3'h1;
        enc_set_i = 3'h4;
        nx(1);
        {enc_next_i, enc_set_i} = 6'h00;
        far_u.quad(1, 4);
        enc_num_i = 2'h3;
        far_u.mark();
        rd({32'h1, 32'h16, 32'hc});
        enc_num_i = 2'h1;
        far_u.mark();
        far_u.quad(1, 4);
        enc_rref_i = 3'h1;
        nx(1);
        enc_rref_i = 3'h0;
        far_u.mark();
        rd({32'h5, 32'h14, 32'ha});
        $display("done: reference marks");
        trg_cfg_i.mode = TRG_ENC;
        trg_cfg_i.lo = 32'hb;
        trg_cfg_i.hi = 32'hd;
        trg_cfg_i.inc = 32'h2;
        // move just after a pulse, so no cycle start splits hit and record
        for (int i = 0; i < 3; i++) begin
            wcyc();
            far_u.quad(1, 4);
            run(1, (i == 1) ? 0 : 1);
        end
        chk(val_enc_o[0], 32'hd, "trigger position");
        trg_cfg_i.mode = TRG_SOFT;
        trg_cfg_i.burst_n = 16'h2;
        run(1, 0);
        soft_trig_i = 1'b1;
        nx(1);
        soft_trig_i = 1'b0;
        run(3, 2);
        trg_cfg_i.burst_inf = 1'b1;
        soft_trig_i = 1'b1;
        nx(1);
        soft_trig_i = 1'b0;
        run(3, 3);
        trg_cfg_i.mode = TRG_OFF;
        run(2, 2);
        $display("done: encoder and software triggers");
        // pin now serves as trigger input at the internal rate
        far_u.peer_on = 1'b0;
        sync_role_i = SYNC_MFI;
        far_u.pin(1'b0);
        trg_cfg_i.mode = TRG_LEVEL;
        trg_cfg_i.pol_high = 1'b1;
        far_u.pin(1'b1);
        run(2, 2);
        far_u.pin(1'b0);
        run(1, 0);
        trg_cfg_i.mode = TRG_EDGE;
        trg_cfg_i.burst_inf = 1'b0;
        trg_cfg_i.burst_n = 16'h1;
        far_u.pin(1'b1);
        run(2, 1);
        far_u.pin(1'b0);
        $display("done: pin triggers");
        print_verdict();
    end
endmodule
